//--- stop_bar_consts.vh
// Purpose: shared constants of the stop bar sequencer
// Assumes: 250 MHz system clock, 1 ms timer tick
// Notes:   register offsets are byte addresses on AXI4-Lite
`ifndef STOP_BAR_CONSTS_VH
`define STOP_BAR_CONSTS_VH

// timing
`define CLK_PERIOD_NS    4
`define TICK_PERIOD_NS   1000000
`define TICK_PER_S       1000
`define BACKUP1_S        45
`define BACKUP2_S        120
`define AUTO_OFF_S       600
`define FLASH_HALF_MS    20'h003C7
`define TMR_W            20

// register map
`define REG_CTRL         4'h0
`define REG_SERVICE      4'h4
`define REG_STATUS       4'h8
`define REG_MONITOR      4'hC

// control fields
`define CTRL_SYS_ON      0
`define CTRL_VIS_LO      1
`define CTRL_VIS_HI      2
`define CTRL_AUTO_OFF    3
`define CTRL_COMBINED    4
`define CTRL_INT_LO      8
`define CTRL_INT_HI      9
`define CTRL_RESET       10'h000
`define SERVICE_BIT      0

// visibility mode encodings
`define VIS_ABOVE        2'h0
`define VIS_AT           2'h1
`define VIS_BELOW        2'h2

// fixtures
`define LAMPS            8
`define FAIL_CNT_W       4

// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- seq_timer.v
// Purpose: restartable tick counter used for backup, shutoff and flash timing
// Assumes: tick is a one-cycle pulse
// Notes:   done pulses for one cycle when LIMIT ticks have passed
`timescale 1ns/1ps
`default_nettype none

module seq_timer #(
    parameter [19:0] LIMIT = 20'h00001
) (
    input  wire       clk_sys,   // system clock
    input  wire       rst_n,     // synchronous reset, active low
    input  wire       tick,      // timebase pulse
    input  wire       start,     // (re)start from zero
    input  wire       cancel,    // stop without done
    output reg        running,   // counting
    output reg        done       // expiry pulse
);

    reg [19:0] cnt_ff;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_ff  <= 20'h00000;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_ff  <= 20'h00000;
                running <= 1'b1;
            end else if (cancel) begin
                running <= 1'b0;
            end else if (running && tick) begin
                if (cnt_ff == LIMIT - 20'h00001) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 20'h00001;
                end
            end
        end
    end

endmodule // seq_timer

`default_nettype wire

//--- stop_bar_sequencer.v
// Purpose: controlled stop bar and lead-on sequencer with failure modes
// Assumes: lamp health and controller faults arrive as synchronous levels
// Notes:   registers over AXI4-Lite; timers run from a 1 ms tick
//
// Summary of operation
// - system on lights all stop bars together at one common intensity.
// - button press starts both timers, bar off, both lead-on segments on.
// - first backup timer runs 45 s standing in for sensor 1.
// - second backup timer runs 2 min standing in for sensor 2.
// - timer expiry acts exactly as detection by its sensor.
// - sensor 1 relights the bar and turns segment 1 off.
// - sensor 2 turns segment 2 off.
// - sensor 2 during timer 1 turns both segments off, bar on.
// - press with override held ignores both sensors that sequence.
// - override sequence returns to initial state only at timer 2 expiry.
// - one failed lamp leaves all other lamps working normally.
// - failed local controller forces its lamps off.
// - control failure at or below threshold: bar fails on, failed lamps off.
// - control failure above threshold: bar and all lamps fail off.
// - optional ten minute timer switches a failed bar off.
// - failed bar indication holds until returned to service.
// - bar off and lead-on on within two seconds of press.
// - monitored light state reported within five seconds of press.
// - monitor reports failed lamp count and neighbour failures.
// - combined fixture: yellow at or above threshold, red at or below.
// - combined comm failure: below red on yellow off, else yellow pulses.
// - combined controller fault forces red and yellow off.
// - yellow pulses even/odd alternately, half cycle each, 30-32 per minute.
`timescale 1ns/1ps
`default_nettype none
`include "stop_bar_consts.vh"

module stop_bar_sequencer #(
    parameter [19:0] TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
    parameter [19:0] T1_TICKS    = `BACKUP1_S * `TICK_PER_S,
    parameter [19:0] T2_TICKS    = `BACKUP2_S * `TICK_PER_S,
    parameter [19:0] OFF_TICKS   = `AUTO_OFF_S * `TICK_PER_S
) (
    input  wire                 clk_sys,            // system clock
    input  wire                 rst_n,              // synchronous reset, active low
    input  wire                 stop_btn,           // stop bar button
    input  wire                 override_btn,       // sensor override button
    input  wire                 sensor1,            // vehicle sensor 1
    input  wire                 sensor2,            // vehicle sensor 2
    input  wire                 comm_fail,          // control/communication failure
    input  wire [`LAMPS-1:0]    lamp_ok,            // per-lamp health
    input  wire [1:0]           ctrl_fault,         // local controller fault, even/odd
    output reg  [`LAMPS-1:0]    stop_lamp_on,       // red stop bar lamps
    output reg  [`LAMPS-1:0]    yellow_lamp_on,     // combined fixture yellow lamps
    output reg                  seg1_on,            // lead-on segment 1
    output reg                  seg2_on,            // lead-on segment 2
    output reg                  uncontrolled_on,    // uncontrolled stop bars
    output reg  [1:0]           intensity,          // common intensity step
    output reg                  failed_ind,         // failed stop bar indication
    input  wire [31:0]          s_axi_awaddr,       // write address
    input  wire                 s_axi_awvalid,      // write address valid
    output wire                 s_axi_awready,      // write address ready
    input  wire [31:0]          s_axi_wdata,        // write data
    input  wire [3:0]           s_axi_wstrb,        // write strobes
    input  wire                 s_axi_wvalid,       // write data valid
    output wire                 s_axi_wready,       // write data ready
    output reg  [1:0]           s_axi_bresp,        // write response
    output reg                  s_axi_bvalid,       // write response valid
    input  wire                 s_axi_bready,       // write response ready
    input  wire [31:0]          s_axi_araddr,       // read address
    input  wire                 s_axi_arvalid,      // read address valid
    output wire                 s_axi_arready,      // read address ready
    output reg  [31:0]          s_axi_rdata,        // read data
    output reg  [1:0]           s_axi_rresp,        // read response
    output reg                  s_axi_rvalid,       // read valid
    input  wire                 s_axi_rready        // read ready
);

    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_CLEAR = 4'h2;
    localparam [3:0] ST_SEG2  = 4'h4;
    localparam [3:0] ST_OVR   = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detect
    reg  [3:0]  sync1_ff;
    reg  [3:0]  sync2_ff;
    reg  [3:0]  prev_ff;
    wire [3:0]  rise;
    wire        press;
    wire        det1;
    wire        det2;
    wire        ovr_held;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            prev_ff  <= 4'h0;
        end else begin
            sync1_ff <= {sensor2, sensor1, override_btn, stop_btn};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end
    assign rise     = sync2_ff & ~prev_ff;
    assign press    = rise[0];
    assign ovr_held = sync2_ff[1];
    assign det1     = rise[2];
    assign det2     = rise[3];

    ////////////////////////////////////////////////////////////////////////////
    // timebase
    reg  [19:0] tick_cnt_ff;
    reg         tick_ff;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            tick_cnt_ff <= 20'h00000;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff == TICK_CYCLES - 20'h00001) begin
            tick_cnt_ff <= 20'h00000;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 20'h00001;
            tick_ff     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    reg  [9:0]  ctrl_ff;
    wire        sys_on    = ctrl_ff[`CTRL_SYS_ON];
    wire [1:0]  vis_mode  = ctrl_ff[`CTRL_VIS_HI:`CTRL_VIS_LO];
    wire        auto_off  = ctrl_ff[`CTRL_AUTO_OFF];
    wire        combined  = ctrl_ff[`CTRL_COMBINED];
    wire        vis_above = (vis_mode == `VIS_ABOVE);
    wire        vis_below = (vis_mode == `VIS_BELOW);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    wire        t1_run;
    wire        t1_done;
    wire        t2_run;
    wire        t2_done;
    wire        seq_start = press && (state_ff == ST_IDLE) && sys_on && !comm_fail;
    wire        seq_end   = (nxt_state == ST_IDLE) && (state_ff != ST_IDLE);

    seq_timer #(.LIMIT(T1_TICKS)) u_t1 (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick_ff),
        .start   (seq_start),
        .cancel  (seq_end),
        .running (t1_run),
        .done    (t1_done)
    );

    seq_timer #(.LIMIT(T2_TICKS)) u_t2 (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick_ff),
        .start   (seq_start),
        .cancel  (seq_end),
        .running (t2_run),
        .done    (t2_done)
    );

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (seq_start) begin
                    nxt_state = ovr_held ? ST_OVR : ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                // sensor 2 before timer 1 ends
                if (det2 || t2_done) begin
                    nxt_state = ST_IDLE;
                end else if (det1 || t1_done) begin
                    nxt_state = ST_SEG2;
                end
            end
            ST_SEG2: begin
                if (det2 || t2_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_OVR: begin
                if (t2_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (!sys_on || comm_fail) begin
            nxt_state = ST_IDLE;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // failure handling
    reg         fail_prev_ff;
    reg         off_done_ff;
    wire        off_run;
    wire        off_done;
    wire        fail_rise = comm_fail && !fail_prev_ff;
    wire        svc_write;

    seq_timer #(.LIMIT(OFF_TICKS)) u_off (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick_ff),
        .start   (fail_rise && auto_off),
        .cancel  (!comm_fail || !auto_off),
        .running (off_run),
        .done    (off_done)
    );

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            fail_prev_ff <= 1'b0;
            off_done_ff  <= 1'b0;
            failed_ind   <= 1'b0;
        end else begin
            fail_prev_ff <= comm_fail;
            if (off_done) begin
                off_done_ff <= 1'b1;
            end else if (!comm_fail) begin
                off_done_ff <= 1'b0;
            end
            // hold until return to service, set wins
            if (comm_fail) begin
                failed_ind <= 1'b1;
            end else if (svc_write) begin
                failed_ind <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash phase
    reg         phase_ff;
    wire        flash_done;

    seq_timer #(.LIMIT(`FLASH_HALF_MS)) u_flash (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick_ff),
        .start   (flash_done || !sys_on),
        .cancel  (1'b0),
        .running (),
        .done    (flash_done)
    );

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_ff <= 1'b0;
        end else if (flash_done) begin
            phase_ff <= ~phase_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lamp drive; outputs registered so they land one cycle after the event
    reg         bar_cmd;
    reg         yel_cmd;
    reg  [`LAMPS-1:0] nxt_stop;
    reg  [`LAMPS-1:0] nxt_yel;
    integer     i;

    always @* begin
        bar_cmd = 1'b0;
        yel_cmd = 1'b0;
        if (comm_fail) begin
            // fail on at or below threshold; combined fixture red fails on only below
            bar_cmd = combined ? vis_below : !vis_above;
            yel_cmd = combined && !vis_below;
            if (off_done_ff) begin
                bar_cmd = 1'b0;
            end
        end else if (sys_on) begin
            bar_cmd = (state_ff == ST_IDLE) || (state_ff == ST_SEG2);
            if (combined && vis_above) begin
                bar_cmd = 1'b0;
            end
            yel_cmd = combined && !vis_below;
        end
        for (i = 0; i < `LAMPS; i = i + 1) begin
            // controller fault forces its lamps off
            // both colours off on controller fault
            nxt_stop[i] = bar_cmd && lamp_ok[i] && !ctrl_fault[i % 2];
            nxt_yel[i]  = yel_cmd && lamp_ok[i] && !ctrl_fault[i % 2]
                          && (phase_ff == (i % 2 == 1));
        end
    end

    // lights follow the press within a few cycles
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stop_lamp_on    <= {`LAMPS{1'b0}};
            yellow_lamp_on  <= {`LAMPS{1'b0}};
            seg1_on         <= 1'b0;
            seg2_on         <= 1'b0;
            uncontrolled_on <= 1'b0;
            intensity       <= 2'h0;
        end else begin
            stop_lamp_on    <= nxt_stop;
            yellow_lamp_on  <= nxt_yel;
            seg1_on         <= !comm_fail && ((state_ff == ST_CLEAR) || (state_ff == ST_OVR));
            seg2_on         <= !comm_fail && (state_ff != ST_IDLE);
            uncontrolled_on <= comm_fail ? bar_cmd : sys_on;
            intensity       <= ctrl_ff[`CTRL_INT_HI:`CTRL_INT_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // monitor
    reg  [`FAIL_CNT_W-1:0] fail_cnt;
    reg                    adjacent;
    integer                k;

    always @* begin
        fail_cnt = {`FAIL_CNT_W{1'b0}};
        adjacent = 1'b0;
        for (k = 0; k < `LAMPS; k = k + 1) begin
            fail_cnt = fail_cnt + {{(`FAIL_CNT_W-1){1'b0}}, !lamp_ok[k]};
            if (k > 0 && !lamp_ok[k] && !lamp_ok[k-1]) begin
                adjacent = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    reg         aw_ok_ff;
    reg  [3:0]  aw_addr_ff;
    reg         aw_map_ff;
    reg         w_ok_ff;
    reg  [31:0] w_data_ff;
    reg  [3:0]  w_strb_ff;
    wire        wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
    wire [3:0]  ar_low = s_axi_araddr[3:0];
    wire        ar_map = (s_axi_araddr[31:4] == 28'h0000000) && (ar_low[1:0] == 2'h0);

    assign s_axi_awready = !aw_ok_ff;
    assign s_axi_wready  = !w_ok_ff;
    assign s_axi_arready = !s_axi_rvalid;
    assign svc_write     = wr_go && aw_map_ff && (aw_addr_ff == `REG_SERVICE)
                           && w_strb_ff[0] && w_data_ff[`SERVICE_BIT];

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_ok_ff     <= 1'b0;
            aw_addr_ff   <= 4'h0;
            aw_map_ff    <= 1'b0;
            w_ok_ff      <= 1'b0;
            w_data_ff    <= 32'h00000000;
            w_strb_ff    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            ctrl_ff      <= `CTRL_RESET;
        end else begin
            if (s_axi_awvalid && !aw_ok_ff) begin
                aw_ok_ff   <= 1'b1;
                aw_addr_ff <= s_axi_awaddr[3:0];
                aw_map_ff  <= (s_axi_awaddr[31:4] == 28'h0000000)
                              && (s_axi_awaddr[1:0] == 2'h0);
            end
            if (s_axi_wvalid && !w_ok_ff) begin
                w_ok_ff   <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ok_ff     <= 1'b0;
                w_ok_ff      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_map_ff ? `RESP_OKAY : `RESP_SLVERR;
                if (aw_map_ff && aw_addr_ff == `REG_CTRL) begin
                    if (w_strb_ff[0]) begin
                        ctrl_ff[7:0] <= w_data_ff[7:0];
                    end
                    if (w_strb_ff[1]) begin
                        ctrl_ff[9:8] <= w_data_ff[9:8];
                    end
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // live monitored state readable at any time
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ar_map ? `RESP_OKAY : `RESP_SLVERR;
            s_axi_rdata  <= 32'h00000000;
            if (ar_map) begin
                case (ar_low)
                    `REG_CTRL:    s_axi_rdata <= {22'h000000, ctrl_ff};
                    `REG_STATUS:  s_axi_rdata <= {16'h0000, stop_lamp_on,
                                                  state_ff, off_run, failed_ind,
                                                  seg2_on, seg1_on};
                    `REG_MONITOR: s_axi_rdata <= {16'h0000, lamp_ok, 2'h0,
                                                  t2_run, t1_run, adjacent,
                                                  fail_cnt[2:0]};
                    default:      s_axi_rdata <= 32'h00000000;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // stop_bar_sequencer

`default_nettype wire

//--- stop_bar_chk.sv
// Purpose: port checks of stop_bar_sequencer
// Assumes: outputs lag their causes by one edge
// Notes:   mode register is unseen, so checks hold in every mode
`timescale 1ns/1ps
`default_nettype none
module stop_bar_chk (
    input wire logic       clk_sys,        // clock
    input wire logic       rst_n,          // reset
    input wire logic       comm_fail,      // failure
    input wire logic [7:0] lamp_ok,        // health
    input wire logic [1:0] ctrl_fault,     // faults
    input wire logic [7:0] stop_lamp_on,   // red
    input wire logic [7:0] yellow_lamp_on, // yellow
    input wire logic       seg1_on,        // seg 1
    input wire logic       seg2_on,        // seg 2
    input wire logic       failed_ind,     // indication
    input wire logic       s_axi_bvalid,   // b valid
    input wire logic       s_axi_bready,   // b ready
    input wire logic [1:0] s_axi_bresp     // b resp
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////
    a_fault_even_off:
        assert property (ctrl_fault[0] [*3] |-> ((stop_lamp_on | yellow_lamp_on) & 8'h55) == 8'h00)
        else $error("even lamps lit");
    a_fault_odd_off:
        assert property (ctrl_fault[1] [*3] |-> ((stop_lamp_on | yellow_lamp_on) & 8'hAA) == 8'h00)
        else $error("odd lamps lit");
    a_failed_lamp_dark:
        assert property ((comm_fail && $stable(lamp_ok)) [*3] |-> (stop_lamp_on & ~lamp_ok) == 8'h00)
        else $error("failed lamp lit");
    a_ind_on_fail:
        assert property ($rose(comm_fail) |=> failed_ind)
        else $error("indication late");
    a_ind_holds:
        assert property ($fell(failed_ind) |-> $rose(s_axi_bvalid) && !$past(comm_fail))
        else $error("indication dropped");
    a_fail_segs_off:
        assert property (comm_fail [*4] |-> !seg1_on && !seg2_on)
        else $error("segments lit in failure");
    a_press_bar_off:
        assert property ($rose(seg1_on) |-> stop_lamp_on == 8'h00 && seg2_on)
        else $error("bar lit at press");
    a_seg1_relit:
        assert property ($fell(seg1_on) && seg2_on && lamp_ok == 8'hFF && ctrl_fault == 2'h0
            && !comm_fail |-> (stop_lamp_on | yellow_lamp_on) != 8'h00)
        else $error("bar dark after seg 1");
    a_bresp_stands:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    c_press: cover property ($rose(seg1_on));
    c_fail: cover property ($rose(failed_ind));
    c_end: cover property ($fell(seg2_on) && !comm_fail);
endmodule // stop_bar_chk
bind stop_bar_sequencer stop_bar_chk stop_bar_chk_i (.*);
`default_nettype wire

//--- stop_bar_far.sv
// Purpose: tower panel and vehicle sensors facing the sequencer
// Assumes: pulse is called just after a rising edge
// Notes:   levels held four edges so each is one clean event
`timescale 1ns/1ps
`default_nettype none
module stop_bar_far (
    input wire logic clk_sys,      // clock
    output var logic stop_btn,     // button
    output var logic override_btn, // override
    output var logic sensor1,      // sensor 1
    output var logic sensor2       // sensor 2
);
    initial {sensor2, sensor1, stop_btn, override_btn} = 4'h0;
    task automatic pulse(input logic [2:0] pins, input logic ovr);
        {sensor2, sensor1, stop_btn} <= pins;
        override_btn <= ovr;
        repeat (4) @(posedge clk_sys);
        {sensor2, sensor1, stop_btn, override_btn} <= 4'h0;
        @(posedge clk_sys);
    endtask
endmodule // stop_bar_far
`default_nettype wire

//--- stop_bar_sequencer_test.sv
// Purpose: self-checking bench of stop_bar_sequencer
// Assumes: tick 4 cycles, timers 10, 25 and 20 ticks
// Notes:   timer checks leave at least two ticks of slack either way
`timescale 1ns/1ps
`default_nettype none
`include "stop_bar_consts.vh"
module stop_bar_sequencer_test;
    logic        clk_sys, rst_n, comm_fail, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [7:0]  lamp_ok;
    logic [1:0]  ctrl_fault, lvl, r;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
    wire         stop_btn, override_btn, sensor1, sensor2, seg1_on, seg2_on, uncontrolled_on;
    wire         failed_ind, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid;
    wire  [7:0]  stop_lamp_on, yellow_lamp_on;
    wire  [1:0]  intensity, s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          errors, cmp_count;
    stop_bar_sequencer #(.TICK_CYCLES(20'h00004), .T1_TICKS(20'h0000A),
        .T2_TICKS(20'h00019), .OFF_TICKS(20'h00014)) stop_bar_sequencer_i (.*);
    stop_bar_far stop_bar_far_i (.*);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    ////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic lights(input logic [7:0] e, input logic e1, input logic e2);
        chk("lights", {6'h01, e1, e2, e}, {5'h0, uncontrolled_on, seg1_on, seg2_on, stop_lamp_on});
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    function automatic logic [3:0] mon(input logic [7:0] ok);
        logic [7:0] f;
        f = ~ok;
        return {|(f & (f >> 1)), 3'($countones(f))};
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////
    initial begin
        {rst_n, comm_fail, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        lamp_ok = 8'hFF;
        ctrl_fault = 2'h0;
        void'($urandom(32'h710f));
        cyc(10);
        rst_n <= 1'b1;
        cyc(1);
        rd(32'h0);
        chk("ctrl", 16'h0, d[15:0]);
        rd(32'h10);
        chk("bad_addr", {14'h0, `RESP_SLVERR}, {d[13:0], r});
        lvl = 2'($urandom);
        wr(32'h0, {22'h0, lvl, 8'h03});
        cyc(2);
        chk("common", {13'h0, 1'b1, lvl}, {13'h0, uncontrolled_on, intensity});
        lights(8'hFF, 1'b0, 1'b0);
        stop_bar_far_i.pulse(3'b001, 1'b0);
        cyc(2);
        lights(8'h00, 1'b1, 1'b1);
        rd(32'h8);
        chk("status", 16'h0023, d[15:0] & 16'hFFF7);
        stop_bar_far_i.pulse(3'b010, 1'b0);
        cyc(2);
        lights(8'hFF, 1'b0, 1'b1);
        stop_bar_far_i.pulse(3'b100, 1'b0);
        cyc(2);
        lights(8'hFF, 1'b0, 1'b0);
        stop_bar_far_i.pulse(3'b001, 1'b0);
        stop_bar_far_i.pulse(3'b100, 1'b0);
        cyc(2);
        lights(8'hFF, 1'b0, 1'b0);
        // timers alone, with a stray press midway
        stop_bar_far_i.pulse(3'b001, 1'b0);
        cyc(25);
        lights(8'h00, 1'b1, 1'b1);
        cyc(24);
        lights(8'hFF, 1'b0, 1'b1);
        stop_bar_far_i.pulse(3'b001, 1'b0);
        cyc(2);
        lights(8'hFF, 1'b0, 1'b1);
        cyc(31);
        lights(8'hFF, 1'b0, 1'b1);
        cyc(25);
        lights(8'hFF, 1'b0, 1'b0);
        stop_bar_far_i.pulse(3'b001, 1'b1);
        stop_bar_far_i.pulse(3'b010, 1'b0);
        stop_bar_far_i.pulse(3'b100, 1'b0);
        cyc(77);
        lights(8'h00, 1'b1, 1'b1);
        cyc(25);
        lights(8'hFF, 1'b0, 1'b0);
        lamp_ok <= 8'($urandom);
        ctrl_fault <= 2'($urandom);
        comm_fail <= 1'b1;
        cyc(4);
        chk("fail_on", {8'h0, lamp_ok & ~{4{ctrl_fault}}}, {8'h0, stop_lamp_on});
        rd(32'hC);
        chk("monitor", {lamp_ok, 4'h0, mon(lamp_ok)}, d[15:0] & 16'hFF0F);
        wr(32'h0, {22'h0, lvl, 8'h01});
        cyc(2);
        chk("fail_off", 16'h0, {8'h0, stop_lamp_on});
        comm_fail <= 1'b0;
        cyc(4);
        chk("failed_ind", 16'h1, {15'h0, failed_ind});
        wr(32'h4, 32'h1);
        cyc(2);
        chk("failed_ind", {14'h0, `RESP_OKAY}, {13'h0, failed_ind, r});
        ctrl_fault <= 2'h0;
        wr(32'h0, {22'h0, lvl, 8'h0B});
        comm_fail <= 1'b1;
        cyc(40);
        chk("auto_on", {8'h0, lamp_ok}, {8'h0, stop_lamp_on});
        cyc(60);
        chk("auto_off", 16'h0, {8'h0, stop_lamp_on});
        comm_fail <= 1'b0;
        cyc(2);
        wr(32'h0, {22'h0, lvl, 8'h13});
        cyc(2);
        chk("yellow", {lamp_ok, lamp_ok & 8'h55}, {stop_lamp_on, yellow_lamp_on});
        wr(32'h0, {22'h0, lvl, 8'h15});
        comm_fail <= 1'b1;
        cyc(4);
        chk("combined", {lamp_ok, 8'h0}, {stop_lamp_on, yellow_lamp_on});
        print_verdict;
    end
    initial begin
        #20000;
        errors++;
        print_verdict;
    end
endmodule // stop_bar_sequencer_test
`default_nettype wire
